/* hw/manchester_tx_regs.svh */
// Register offsets, field positions, reset values and timing figures
// for the Manchester / bit-sequential transmitter.
// Assumes a Wishbone slave with byte addresses, one register per word.
`ifndef MANCHESTER_TX_REGS_SVH
`define MANCHESTER_TX_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_CODER_CONTROL     16'hFF60
`define IDX_BASE_CLOCK_SELECT 16'hFF61
`define IDX_RATE_DIVIDER      16'hFF62
`define IDX_CODER_STATUS      16'hFF63
`define IDX_TRANSMIT_DATA     16'hFF64
`define IDX_BIT_COUNT         16'hFF65

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CODER_ENABLE_BIT    7
`define FIRST_BIT_ORDER_BIT 4
`define OUTPUT_FORMAT_BIT   1
`define IDLE_LEVEL_BIT      0
`define BUSY_FLAG_BIT       7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CODER_CONTROL     8'h10
`define RST_BASE_CLOCK_SELECT 8'h00
`define RST_RATE_DIVIDER      8'h1F
`define RST_BIT_COUNT         8'h07
`define RST_TRANSMIT_DATA     8'hFF

// ----------------------------------------------------------------------
// Divider figures
// ----------------------------------------------------------------------
`define RATE_DIV_MIN  5'h04
`define BASE_SEL_MAX  3'h5

`endif

/* hw/manchester_tx_pkg.sv */
// Types shared by the transmitter design.
// Assumes the register header is included by the design file.
package manchester_tx_pkg;

    // ------------------------------------------------------------------
    // Transmitter sequencing states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_e;

endpackage : manchester_tx_pkg

/* hw/manchester_tx.sv */
// Manchester / bit-sequential serial transmitter with Wishbone registers.
// Assumes a classic Wishbone master on ref_clk and a receiver on the pin.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "manchester_tx_regs.svh"

module manchester_tx #(
    parameter int ADDR_W = 18
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Line side
    output logic                   coded_output_pin,
    output logic                   coded_output_oe,
    output logic                   start_interrupt
);
    import manchester_tx_pkg::*;

    // Refuse address widths that cannot reach the register words
    if (ADDR_W < 18) begin : g_addr_check
        $error("ADDR_W too narrow for register map");
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r, rst_sync_r;
    wire  rst_n = rst_sync_r;

    // Async assert, clocked release through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0]  coder_control_r, base_clock_select_r, rate_divider_r;
    logic [7:0]  bit_count_r, transmit_data_r;
    logic        busy_flag_r, pending_r;
    tx_state_e   state_r;

    wire         req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         wr_lane = req && wb_we_i && wb_sel_i[0];
    wire [15:0]  idx     = wb_adr_i[17:2];
    wire         enable  = coder_control_r[`CODER_ENABLE_BIT];
    wire         wr_data = wr_lane && idx == `IDX_TRANSMIT_DATA;

    // Every access answered one cycle after it is seen
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) wb_ack_o <= 1'b0;
        else        wb_ack_o <= req;
    end

    // Read mux; unmapped words read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            case (idx)
                `IDX_CODER_CONTROL:     wb_dat_o <= {24'h0, coder_control_r};
                `IDX_BASE_CLOCK_SELECT: wb_dat_o <= {24'h0, base_clock_select_r};
                `IDX_RATE_DIVIDER:      wb_dat_o <= {24'h0, rate_divider_r};
                `IDX_CODER_STATUS:      wb_dat_o <= {24'h0, busy_flag_r, 7'h00};
                `IDX_TRANSMIT_DATA:     wb_dat_o <= {24'h0, transmit_data_r};
                `IDX_BIT_COUNT:         wb_dat_o <= {24'h0, bit_count_r};
                default:                wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Reserved bits are masked so they always read zero; the count is only
    // touched by its own write, so back-to-back transfers reuse it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coder_control_r     <= `RST_CODER_CONTROL;
            base_clock_select_r <= `RST_BASE_CLOCK_SELECT;
            rate_divider_r      <= `RST_RATE_DIVIDER;
            bit_count_r         <= `RST_BIT_COUNT;
            transmit_data_r     <= `RST_TRANSMIT_DATA;
        end else if (wr_lane) begin
            case (idx)
                `IDX_CODER_CONTROL:     coder_control_r     <= wb_dat_i[7:0] & 8'h93;
                `IDX_BASE_CLOCK_SELECT: base_clock_select_r <= wb_dat_i[7:0] & 8'h07;
                `IDX_RATE_DIVIDER:      rate_divider_r      <= wb_dat_i[7:0] & 8'h1F;
                `IDX_BIT_COUNT:         bit_count_r         <= wb_dat_i[7:0] & 8'h07;
                `IDX_TRANSMIT_DATA:     transmit_data_r     <= wb_dat_i[7:0];
                default:                ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Base clock prescaler and rate divider
    // ------------------------------------------------------------------
    logic [4:0] pre_cnt_r;
    logic [4:0] div_cnt_r;
    logic       rate_clk_r;          // bit-rate square wave, half period = k ticks
    wire  [2:0] sel    = base_clock_select_r[2:0];
    wire  [4:0] k      = (rate_divider_r[4:0] < `RATE_DIV_MIN) ? `RATE_DIV_MIN
                                                               : rate_divider_r[4:0];
    // Codes 6 and 7 are undefined; they are held at the slowest defined rate
    wire  [2:0] sel_eff = (sel > `BASE_SEL_MAX) ? `BASE_SEL_MAX : sel;
    wire  [4:0] pre_mask = 5'((6'h01 << sel_eff) - 6'h01);
    wire        base_tick = (pre_cnt_r & pre_mask) == pre_mask;
    wire        half_tick = base_tick && div_cnt_r == 5'(k - 5'h01);
    wire        bit_end   = half_tick && rate_clk_r;

    // Dividers run only while sending so every bit gets whole periods
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_r  <= 5'h00;
            div_cnt_r  <= 5'h00;
            rate_clk_r <= 1'b0;
        end else if (state_r == TX_IDLE) begin
            pre_cnt_r  <= 5'h00;
            div_cnt_r  <= 5'h00;
            rate_clk_r <= 1'b0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 5'h01;
            if (base_tick) begin
                if (half_tick) begin
                    div_cnt_r  <= 5'h00;
                    rate_clk_r <= !rate_clk_r;
                end else begin
                    div_cnt_r <= div_cnt_r + 5'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------------
    logic [7:0] shift_r;
    logic [2:0] bits_left_r;
    wire        last_bit = bits_left_r == 3'h0;
    wire        lsb_first = coder_control_r[`FIRST_BIT_ORDER_BIT];
    wire        start_now = (state_r == TX_IDLE && pending_r)
                         || (bit_end && last_bit && pending_r);
    // Short transfers: MSB-first moves the top kept bit to bit 7
    wire [7:0]  msb_align = 8'(transmit_data_r << (3'h7 - bit_count_r[2:0]));
    wire        cur_bit   = lsb_first ? shift_r[0] : shift_r[7];

    // Data written while enabled waits here until the shifter takes it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)            pending_r <= 1'b0;
        else if (!enable)      pending_r <= 1'b0;
        else if (wr_data)      pending_r <= 1'b1;
        else if (start_now)    pending_r <= 1'b0;
    end

    // State, counter and shifter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= TX_IDLE;
            shift_r     <= 8'h00;
            bits_left_r <= 3'h0;
        end else if (!enable) begin
            state_r     <= TX_IDLE;
        end else begin
            case (state_r)
                TX_IDLE: begin
                    if (start_now) state_r <= TX_SEND;
                end
                TX_SEND: begin
                    if (bit_end && last_bit && !pending_r) state_r <= TX_IDLE;
                end
                default: state_r <= TX_IDLE;
            endcase
            if (start_now) begin
                bits_left_r <= bit_count_r[2:0];
                shift_r     <= lsb_first ? transmit_data_r : msb_align;
            end else if (bit_end && !last_bit) begin
                bits_left_r <= bits_left_r - 3'h1;
                shift_r     <= lsb_first ? {1'b0, shift_r[7:1]} : {shift_r[6:0], 1'b0};
            end
        end
    end

    // Busy covers the whole chain of transfers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)       busy_flag_r <= 1'b0;
        else if (!enable) busy_flag_r <= 1'b0;
        else              busy_flag_r <= (state_r == TX_SEND && !(bit_end && last_bit
                                          && !pending_r)) || start_now;
    end

    // ------------------------------------------------------------------
    // Line outputs
    // ------------------------------------------------------------------
    // Manchester output: bit xor rate clock; sequential holds the bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coded_output_pin <= 1'b0;
            coded_output_oe  <= 1'b0;
            start_interrupt  <= 1'b0;
        end else begin
            coded_output_oe <= enable;
            start_interrupt <= enable && start_now;
            if (state_r == TX_SEND)
                coded_output_pin <= coder_control_r[`OUTPUT_FORMAT_BIT] ? cur_bit
                                  : cur_bit ^ rate_clk_r;
            else
                coded_output_pin <= coder_control_r[`IDLE_LEVEL_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    start_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_data && !enable) |=> !pending_r) else $error("start while disabled");
    idle_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_r == TX_IDLE) ##1 $stable(coder_control_r) |->
        coded_output_pin == coder_control_r[`IDLE_LEVEL_BIT])
        else $error("idle level wrong");
    status_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !enable |=> !busy_flag_r) else $error("busy while disabled");
    start_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && start_now) |=> start_interrupt && busy_flag_r)
        else $error("start pulse missing");
    load_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && start_now) |=> bits_left_r == $past(bit_count_r[2:0]))
        else $error("count not loaded");
    pin_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !enable |=> !coded_output_oe) else $error("pin not released");
    chain_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && bit_end && last_bit && pending_r) |=> state_r == TX_SEND && busy_flag_r)
        else $error("chain broken");
    rate_min_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        half_tick |-> div_cnt_r >= 5'h03) else $error("divider below four");
    seq_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && state_r == TX_SEND && coder_control_r[`OUTPUT_FORMAT_BIT]
         && !bit_end && !start_now) ##1 (enable && state_r == TX_SEND)
        |=> $stable(coded_output_pin)) else $error("sequential bit moved");
    // Loads: MSB-first short words start at their top kept bit
    short_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && start_now && !lsb_first) |=>
        shift_r[7] == $past(transmit_data_r[bit_count_r[2:0]]))
        else $error("short word misaligned");
    lsb_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && start_now && lsb_first) |=> shift_r == $past(transmit_data_r))
        else $error("lsb-first load wrong");
    count_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && bit_end && !last_bit) |=> bits_left_r == 3'($past(bits_left_r) - 3'h1))
        else $error("bit count skipped");
    // Manchester must flip at mid-bit, or the receiver loses lock
    mid_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && state_r == TX_SEND && !coder_control_r[`OUTPUT_FORMAT_BIT]
         && half_tick && !rate_clk_r) ##1 enable |=> $changed(coded_output_pin))
        else $error("no mid-bit transition");
    busy_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && bit_end && last_bit && !pending_r) |=> !busy_flag_r)
        else $error("busy after last bit");
    stop_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !enable |=> state_r == TX_IDLE && !start_interrupt)
        else $error("activity while disabled");
    // With a divided base clock, ticks never come on two edges in a row
    base_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (enable && state_r == TX_SEND && base_tick && sel_eff != 3'h0) |=> !base_tick)
        else $error("base tick too close");

endmodule : manchester_tx

/* sim/manchester_rx_model.sv */
// Receiver model: decodes the coded line after each start pulse.
// Assumes the bench supplies the half-bit length in ref_clk cycles.
`timescale 1ns/1ps

module manchester_rx_model (
    // Clock
    input  wire logic        ref_clk,
    // Line
    input  wire logic        line_in,
    input  wire logic        line_oe,
    input  wire logic        start_in,
    // Settings
    input  wire logic [15:0] half_len,
    input  wire logic [3:0]  n_bits,
    input  wire logic        seq_format,
    // Results
    output logic      [7:0]  rx_word,
    output int               rx_count,
    output int               code_errs
);
    // ------------------------------------------------------------
    // Mid-half sampling
    // ------------------------------------------------------------
    int         cnt;
    int         pos;
    logic       active = 1'b0;
    logic       first;
    logic [7:0] acc;

    initial code_errs = 0;
    initial rx_count = 0;

    // Sample one cycle past mid-half so the pin's register lag is covered
    always @(posedge ref_clk) begin
        if (start_in === 1'b1) begin
            active = 1'b1;
            cnt = 0;
            acc = 8'h00;
        end else if (line_oe !== 1'b1) begin
            active = 1'b0;
        end else if (active) begin
            cnt = cnt + 1;
            pos = cnt % (2 * half_len);
            if (pos == half_len / 2 + 1) first = line_in;
            if (pos == half_len + half_len / 2 + 1) begin
                acc = {acc[6:0], first};
                if (line_in !== (seq_format ? first : ~first)) code_errs <= code_errs + 1;
                if (cnt / (2 * half_len) == n_bits - 1) begin
                    rx_word  <= acc;
                    rx_count <= rx_count + 1;
                    active = 1'b0;
                end
            end
        end
    end
endmodule : manchester_rx_model

/* sim/test_manchester_bitstream_transmitter.sv */
// Self-checking bench for the coded serial transmitter.
// Assumes the receiver model and the register header are on the path.
`timescale 1ns/1ps
`include "manchester_tx_regs.svh"

module test_manchester_bitstream_transmitter;
    import manchester_tx_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        ref_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, seen;
    logic        coded_output_pin, coded_output_oe, start_interrupt, seq_format, f, o, l;
    logic [17:0] wb_adr_i;
    logic [3:0]  wb_sel_i, n_bits;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] half_len;
    logic [7:0]  rx_word, d;
    logic [4:0]  k;
    logic [2:0]  c, s;
    int          rx_count, code_errs, mismatches, n_compared, seed, cycles, t0, n0;
    logic [15:0] r_idx [6] = '{`IDX_CODER_CONTROL, `IDX_BASE_CLOCK_SELECT, `IDX_RATE_DIVIDER,
                               `IDX_CODER_STATUS, `IDX_TRANSMIT_DATA, `IDX_BIT_COUNT};
    logic [7:0]  r_rst [6] = '{`RST_CODER_CONTROL, `RST_BASE_CLOCK_SELECT, `RST_RATE_DIVIDER,
                               8'h00, `RST_TRANSMIT_DATA, `RST_BIT_COUNT};

    manchester_tx dut_u (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .coded_output_pin(coded_output_pin), .coded_output_oe(coded_output_oe),
        .start_interrupt(start_interrupt));
    manchester_rx_model rx_u (.ref_clk(ref_clk), .line_in(coded_output_pin),
        .line_oe(coded_output_oe), .start_in(start_interrupt), .half_len(half_len),
        .n_bits(n_bits), .seq_format(seq_format), .rx_word(rx_word), .rx_count(rx_count),
        .code_errs(code_errs));

    // Clock, plus a free cycle count for interval checks
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cycles <= cycles + 1;

    // ------------------------------------------------------------
    // Expectations and bus tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] half_of(input logic [2:0] sel, input logic [4:0] kf);
        // Select codes above the top one behave as the top one
        return 16'((kf < `RATE_DIV_MIN) ? `RATE_DIV_MIN : kf)
               << ((sel > `BASE_SEL_MAX) ? `BASE_SEL_MAX : sel);
    endfunction : half_of

    // Bits in line order, always taken from the low end of the byte
    function automatic logic [7:0] exp_word(input logic [7:0] dv, input int n, input logic lsb);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < n; i++) r = {r[6:0], lsb ? dv[i] : dv[n - 1 - i]};
        return r;
    endfunction : exp_word

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Single classic cycle; held until ack is sampled, then released
    task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] wd);
        int i;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        rd = wb_dat_o;
        seen = wb_ack_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (seen !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
    endtask : wb

    // Waits for a start pulse (which 0) or a decoded word count (which 1)
    task automatic wait_for(input int which, input int lim, input int target);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge ref_clk);
            seen = (which == 0) ? start_interrupt === 1'b1 : rx_count >= target;
        end
    endtask : wait_for

    task automatic need(input int which, input int lim, input int target);
        wait_for(which, lim, target);
        if (!seen) begin
            mismatches++;
            report_and_stop();
        end
    endtask : need

    // Set-up always goes through the disabled state first
    task automatic setup(input logic [2:0] cn, input logic fm, input logic lsb,
                         input logic idle, input logic [2:0] sel, input logic [4:0] kf);
        wb(1'b1, `IDX_CODER_CONTROL, 8'h00);
        wb(1'b1, `IDX_BASE_CLOCK_SELECT, {5'h00, sel});
        wb(1'b1, `IDX_RATE_DIVIDER, {3'h0, kf});
        wb(1'b1, `IDX_BIT_COUNT, {5'h00, cn});
        wb(1'b1, `IDX_CODER_CONTROL, {1'b1, 2'b00, lsb, 2'b00, fm, idle});
        half_len <= half_of(sel, kf);
        n_bits <= 4'(cn) + 4'h1;
        seq_format <= fm;
        repeat (3) @(posedge ref_clk);
        chk(coded_output_pin, idle);
        chk(coded_output_oe, 1'b1);
    endtask : setup

    task automatic send(input logic [7:0] dv, input logic [2:0] cn, input logic lsb,
                        input logic idle);
        n0 = rx_count + 1;
        wb(1'b1, `IDX_TRANSMIT_DATA, dv);
        need(0, 50, 0);
        wb(1'b0, `IDX_CODER_STATUS, 8'h00);
        chk(rd[7], 1'b1);
        need(1, 20000, n0);
        chk(rx_word, exp_word(dv, cn + 1, lsb));
        chk(code_errs, 0);
        for (int i = 0; i < 200 && rd[7] !== 1'b0; i++) wb(1'b0, `IDX_CODER_STATUS, 8'h00);
        chk(rd[7], 1'b0);
        repeat (2) @(posedge ref_clk);
        chk(coded_output_pin, idle);
    endtask : send

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 18'h00000;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        half_len = 16'h0008;
        n_bits = 4'h1;
        seq_format = 1'b0;
        seed = 32'h5EB1;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Reset values, read-only status, an unmapped place, reserved bits
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, r_idx[i], 8'h00);
            chk(rd, {24'h000000, r_rst[i]});
        end
        wb(1'b1, `IDX_CODER_STATUS, 8'hFF);
        wb(1'b0, `IDX_CODER_STATUS, 8'h00);
        chk(rd, 32'h0);
        wb(1'b0, 16'hFF66, 8'h00);
        chk(rd, 32'h0);
        wb(1'b1, `IDX_CODER_CONTROL, 8'h7F);
        wb(1'b0, `IDX_CODER_CONTROL, 8'h00);
        chk(rd, 32'h13);
        chk(coded_output_oe, 1'b0);
        // Data written while disabled must not start anything
        wb(1'b1, `IDX_TRANSMIT_DATA, 8'hA5);
        wait_for(0, 100, 0);
        chk(seen, 1'b0);
        // Corners: shortest word at the divider floor, longest at the slowest rate
        setup(3'h0, 1'b0, 1'b0, 1'b1, 3'h1, 5'h00);
        send(8'h01, 3'h0, 1'b0, 1'b1);
        setup(3'h7, 1'b1, 1'b1, 1'b0, 3'h5, 5'h1F);
        send(8'hB4, 3'h7, 1'b1, 1'b0);
        setup(3'h1, 1'b1, 1'b0, 1'b1, 3'h6, 5'h04);
        send(8'h02, 3'h1, 1'b0, 1'b1);
        for (int j = 0; j < 14; j++) begin
            d = 8'($random(seed));
            c = 3'($random(seed));
            {f, o, l} = 3'($random(seed));
            s = 3'($unsigned($random(seed)) % 3);
            k = 5'($unsigned($random(seed)) % 13);
            if (half_of(s, k) < 16'h0006) s = 3'h1;
            setup(c, f, o, l, s, k);
            send(d, c, o, l);
        end
        // Back-to-back words, count left as it was; no gap between them
        setup(3'h3, 1'b0, 1'b0, 1'b0, 3'h0, 5'h08);
        n0 = rx_count;
        wb(1'b1, `IDX_TRANSMIT_DATA, 8'h3C);
        need(0, 50, 0);
        t0 = cycles;
        wb(1'b1, `IDX_TRANSMIT_DATA, 8'hC5);
        need(0, 200, 0);
        chk(cycles - t0, 64);
        chk(rx_word, exp_word(8'h3C, 4, 1'b0));
        wb(1'b0, `IDX_CODER_STATUS, 8'h00);
        chk(rd[7], 1'b1);
        need(1, 500, n0 + 2);
        chk(rx_word, exp_word(8'hC5, 4, 1'b0));
        chk(code_errs, 0);
        // Clearing the enable mid-word clears status and releases the pin
        wb(1'b1, `IDX_TRANSMIT_DATA, 8'h5A);
        need(0, 50, 0);
        wb(1'b1, `IDX_CODER_CONTROL, 8'h00);
        wb(1'b0, `IDX_CODER_STATUS, 8'h00);
        chk(rd, 32'h0);
        chk(coded_output_oe, 1'b0);
        report_and_stop();
    end
endmodule : test_manchester_bitstream_transmitter
